// >>> hw/io_bus_pkg.sv
`default_nettype none
package io_bus_pkg;
  // ----------------------------------------------------------------
  // module addresses on the peripheral bus
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_PORT1       = 4'h1;
  localparam logic [3:0] ADDR_PORT2       = 4'h2;
  localparam logic [3:0] ADDR_PORT5       = 4'h5;
  localparam logic [3:0] ADDR_T12_GATE    = 4'h7;
  localparam logic [3:0] ADDR_AUX_SWITCH  = 4'h8;
  localparam logic [3:0] ADDR_SERIAL_BUF  = 4'h9;
  localparam logic [3:0] ADDR_SERIAL_STAT = 4'hA;
  localparam logic [3:0] ADDR_T3_GATE     = 4'hB;
  localparam logic [3:0] ADDR_T3_CTRL     = 4'hC;
  localparam logic [3:0] ADDR_VMON        = 4'hF;
  // ----------------------------------------------------------------
  // reset values and fixed read values
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_AUX_SWITCH   = 4'hF;
  localparam logic [3:0] RST_PORT1        = 4'h9;
  localparam logic [3:0] RST_ONES         = 4'hF;
  localparam logic [3:0] RST_SERIAL_STAT  = 4'hB;
  localparam logic [3:0] RST_T3_CTRL      = 4'h0;
  localparam logic [3:0] RST_HOLD         = 4'h0;
  localparam logic [3:0] IDLE_READ        = 4'hF;
  localparam logic [3:0] PORT1_BITS       = 4'h9;
  localparam logic [7:0] RST_PORT5_CTRL   = 8'hFF;
  localparam logic [7:0] RST_TX_BYTE      = 8'h00;
  // ----------------------------------------------------------------
  // subport banks: one byte per subport, nibble registers in bits 3:0
  // ----------------------------------------------------------------
  localparam int         SUB_COUNT        = 16;
  localparam logic [3:0] T3_CAPTURE_SUB   = 4'h4;
  localparam logic [15:0] T12_VALID_MASK  = 16'h073F;
  localparam logic [15:0] T12_BYTE_MASK   = 16'h0020;
  localparam logic [15:0] T3_VALID_MASK   = 16'h007F;
  localparam logic [15:0] T3_BYTE_MASK    = 16'h0030;
  localparam logic [127:0] T12_RESET      = 128'h00000000_000F070F_0000FF0F_000F0F00;
  localparam logic [127:0] T3_RESET       = 128'h00000000_00000000_000FFFFF_00000F0F;
endpackage
`default_nettype wire

// >>> hw/io_access_if.sv
`timescale 1ns/1ps
`default_nettype none
// one decoded core access, shared by the decoder and its helpers
interface io_access_if;
  logic       valid;
  logic       write;
  logic       aux;
  logic [3:0] addr;
  logic [3:0] wdata;
  modport drive (output valid, output write, output aux, output addr, output wdata);
  modport sink  (input valid, input write, input aux, input addr, input wdata);
endinterface
`default_nettype wire

// >>> hw/aux_switch.sv
`timescale 1ns/1ps
`default_nettype none
module aux_switch
  import io_bus_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   rst,
  io_access_if.sink   io,
  input  wire logic   consume,
  output logic [3:0]  asw_ff,
  output logic        armed_ff
);
  typedef struct packed {
    logic [3:0] auxiliary_switch_select;
    logic       armed;
  } asw_state_t;

  asw_state_t s_ff;
  asw_state_t nxt_s;

  // ----------------------------------------------------------------
  // write-only selector at address 8
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    if (consume) begin
      nxt_s.armed = 1'b0;
    end
    // a new selection wins over a consume in the same cycle
    if (io.valid && io.write && io.addr == ADDR_AUX_SWITCH) begin
      nxt_s.auxiliary_switch_select   = io.wdata;
      nxt_s.armed = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_ff <= '{auxiliary_switch_select: RST_AUX_SWITCH, armed: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign asw_ff   = s_ff.auxiliary_switch_select;
  assign armed_ff = s_ff.armed;
endmodule
`default_nettype wire

// >>> hw/subport_bank.sv
`timescale 1ns/1ps
`default_nettype none
module subport_bank
  import io_bus_pkg::*;
#(
  parameter logic [3:0]   BASE     = 4'h7,
  parameter logic         READABLE = 1'b0,
  parameter logic [15:0]  VALID    = 16'hFFFF,
  parameter logic [15:0]  BYTES    = 16'h0000,
  parameter logic [127:0] RESETS   = '0
) (
  input  wire logic    sys_clk,
  input  wire logic    rst,
  io_access_if.sink    io,
  input  wire logic [7:0] capture,
  output logic [3:0]   rdata,
  output logic [127:0] regs_ff
);
  typedef enum logic [1:0] {SUB_ADDR, SUB_DATA, SUB_HIGH} sub_state_t;
  typedef struct packed {
    sub_state_t   st;
    logic [3:0]   sub;
    logic [3:0]   hold;
    logic [127:0] regs;
  } bank_state_t;

  bank_state_t s_ff;
  bank_state_t nxt_s;
  logic        hit;
  logic        cap_read;

  assign hit      = io.valid && !io.aux && io.addr == BASE;
  assign cap_read = READABLE && s_ff.sub == T3_CAPTURE_SUB;

  // ----------------------------------------------------------------
  // sub-address then data sequence
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    rdata = IDLE_READ;
    if (hit && (io.write || READABLE)) begin
      case (s_ff.st)
        SUB_ADDR: begin
          if (io.write) begin
            nxt_s.sub = io.wdata;
            nxt_s.st  = SUB_DATA;
          end
        end
        SUB_DATA: begin
          nxt_s.st = SUB_ADDR;
          if (BYTES[s_ff.sub]) begin
            nxt_s.st = SUB_HIGH;
            if (io.write) begin
              nxt_s.hold = io.wdata;
            end else if (cap_read) begin
              rdata      = capture[3:0];
              nxt_s.hold = capture[7:4]; // snapshot keeps the byte whole
            end
          end else if (io.write && VALID[s_ff.sub]) begin
            nxt_s.regs[{s_ff.sub, 3'b000} +: 8] = {4'h0, io.wdata};
          end
        end
        SUB_HIGH: begin
          nxt_s.st = SUB_ADDR;
          if (io.write && VALID[s_ff.sub]) begin
            nxt_s.regs[{s_ff.sub, 3'b000} +: 8] = {io.wdata, s_ff.hold};
          end else if (!io.write && cap_read) begin
            rdata = s_ff.hold;
          end
        end
        default: begin
          nxt_s.st = SUB_ADDR;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_ff <= '{st: SUB_ADDR, sub: 4'h0, hold: 4'h0, regs: RESETS};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign regs_ff = s_ff.regs;
endmodule
`default_nettype wire

// >>> hw/io_bus_decoder.sv
// Operation
// - decode 4-bit module address, sixteen addresses, ten modules
// - plain access hits the primary register
// - aux-switch write redirects the named module's next access to auxiliary
// - byte registers move as nibble sequences
// - extended modules hold sixteen subport registers
// - first write sets subport, next accesses it
// - aux switch at 8, write-only, resets ones
// - address 7: write-only timer one/two subports
// - address B: timer three subports, capture read
// - address 5: port data, byte control aux
// - address 1: two-bit port, reset 1xx1
// - address 9: transmit/receive bytes, control one aux
// - address A: serial status/control, control two aux
// - address C: timer three control and status
// - address F: voltage monitor control and status
// - address 2: port data and direction, ones
`timescale 1ns/1ps
`default_nettype none
module io_bus_decoder
  import io_bus_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        io_valid,
  input  wire logic        io_write,
  input  wire logic [3:0]  io_addr,
  input  wire logic [3:0]  io_wdata,
  output logic [3:0]       io_rdata,
  output logic             io_rvalid,
  input  wire logic [3:0]  port1_pins,
  input  wire logic [3:0]  port2_pins,
  input  wire logic [3:0]  port5_pins,
  input  wire logic [7:0]  rx_byte,
  input  wire logic [3:0]  serial_status,
  input  wire logic [7:0]  t3_capture,
  input  wire logic [3:0]  t3_status,
  input  wire logic [3:0]  vmon_status,
  output logic [3:0]       port1_out,
  output logic             port1_drive,
  output logic [3:0]       port2_out,
  output logic [3:0]       port2_dir,
  output logic [3:0]       port5_out,
  output logic [7:0]       port5_ctrl,
  output logic [7:0]       tx_byte,
  output logic             tx_load,
  output logic [3:0]       serial_ctrl1,
  output logic [3:0]       serial_stat_ctrl,
  output logic [3:0]       serial_ctrl2,
  output logic [3:0]       t3_ctrl,
  output logic [3:0]       vmon_ctrl,
  output logic [127:0]     t12_regs,
  output logic [127:0]     t3_regs
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] rdata;
    logic       rvalid;
    logic [3:0] p1_out;
    logic       p1_drive;
    logic [3:0] p2_out;
    logic [3:0] p2_dir;
    logic [3:0] p5_out;
    logic [7:0] p5_ctrl;
    logic [7:0] tx;
    logic       tx_load;
    logic [3:0] serial_control_one;
    logic [3:0] serial_status_control;
    logic [3:0] serial_control_two;
    logic [3:0] t3c;
    logic [3:0] voltage_monitor_control;
    logic       hi;
    logic       hi_aux;
    logic       hi_write;
    logic [3:0] hi_addr;
    logic [3:0] hold;
  } dec_state_t;

  dec_state_t s_ff;
  dec_state_t nxt_s;

  io_access_if bus ();

  logic [3:0] asw_sel;
  logic       asw_armed;
  logic       aux_hit;
  logic       second;
  logic       consume;
  logic [3:0] t12_rd;
  logic [3:0] t3_rd;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte registers reached as two nibbles
  function automatic logic is_byte(input logic [3:0] a, input logic aux, input logic wr);
    is_byte = (!aux && a == ADDR_SERIAL_BUF) || (aux && wr && a == ADDR_PORT5);
  endfunction

  // ----------------------------------------------------------------
  // access routing
  // ----------------------------------------------------------------
  // an armed selection only redirects the module it names
  assign aux_hit = asw_armed && asw_sel == io_addr &&
                   io_addr != ADDR_AUX_SWITCH;

  // second nibble only when the same register kind follows directly
  assign second = s_ff.hi && s_ff.hi_addr == io_addr &&
                  s_ff.hi_aux == aux_hit && s_ff.hi_write == io_write;

  assign bus.valid = io_valid;
  assign bus.write = io_write;
  assign bus.aux   = aux_hit;
  assign bus.addr  = io_addr;
  assign bus.wdata = io_wdata;

  aux_switch u_aux (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .io       (bus.sink),
    .consume  (consume),
    .asw_ff   (asw_sel),
    .armed_ff (asw_armed)
  );

  // timer one/two gateway is write-only
  subport_bank #(
    .BASE     (ADDR_T12_GATE),
    .READABLE (1'b0),
    .VALID    (T12_VALID_MASK),
    .BYTES    (T12_BYTE_MASK),
    .RESETS   (T12_RESET)
  ) u_t12 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .io      (bus.sink),
    .capture (8'h00),
    .rdata   (t12_rd),
    .regs_ff (t12_regs)
  );

  // timer three gateway reads the capture byte at its capture slot
  subport_bank #(
    .BASE     (ADDR_T3_GATE),
    .READABLE (1'b1),
    .VALID    (T3_VALID_MASK),
    .BYTES    (T3_BYTE_MASK),
    .RESETS   (T3_RESET)
  ) u_t3 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .io      (bus.sink),
    .capture (t3_capture),
    .rdata   (t3_rd),
    .regs_ff (t3_regs)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s         = s_ff;
    nxt_s.rvalid  = 1'b0;
    nxt_s.tx_load = 1'b0;
    consume       = 1'b0;
    if (io_valid) begin
      // byte phase tracking; any other access restarts at low nibble
      nxt_s.hi       = 1'b0;
      nxt_s.hi_aux   = aux_hit;
      nxt_s.hi_write = io_write;
      nxt_s.hi_addr  = io_addr;
      if (is_byte(io_addr, aux_hit, io_write) && !second) begin
        nxt_s.hi = 1'b1;
      end
      // selection spent once the whole sequence is done
      if (aux_hit && !(is_byte(io_addr, aux_hit, io_write) && !second)) begin
        consume = 1'b1;
      end
      if (!io_write) begin
        nxt_s.rvalid = 1'b1;
        nxt_s.rdata  = IDLE_READ;
      end
      if (aux_hit) begin
        // auxiliary registers are all write-only
        if (io_write && io_addr == ADDR_PORT2) begin
          nxt_s.p2_dir = io_wdata;
        end else if (io_write && io_addr == ADDR_PORT5) begin
          if (second) begin
            nxt_s.p5_ctrl = {io_wdata, s_ff.hold};
          end else begin
            nxt_s.hold = io_wdata;
          end
        end else if (io_write && io_addr == ADDR_SERIAL_BUF) begin
          nxt_s.serial_control_one = io_wdata;
        end else if (io_write && io_addr == ADDR_SERIAL_STAT) begin
          nxt_s.serial_control_two = io_wdata;
        end
      end else if (io_write) begin
        // primary writes
        if (io_addr == ADDR_PORT1) begin
          nxt_s.p1_out   = io_wdata & PORT1_BITS;
          nxt_s.p1_drive = 1'b1;
        end else if (io_addr == ADDR_PORT2) begin
          nxt_s.p2_out = io_wdata;
        end else if (io_addr == ADDR_PORT5) begin
          nxt_s.p5_out = io_wdata;
        end else if (io_addr == ADDR_SERIAL_BUF) begin
          if (second) begin
            nxt_s.tx      = {io_wdata, s_ff.hold};
            nxt_s.tx_load = 1'b1;
          end else begin
            nxt_s.hold = io_wdata;
          end
        end else if (io_addr == ADDR_SERIAL_STAT) begin
          nxt_s.serial_status_control = io_wdata;
        end else if (io_addr == ADDR_T3_CTRL) begin
          nxt_s.t3c = io_wdata;
        end else if (io_addr == ADDR_VMON) begin
          nxt_s.voltage_monitor_control = io_wdata;
        end
      end else begin
        // primary reads
        if (io_addr == ADDR_PORT1) begin
          nxt_s.rdata    = port1_pins & PORT1_BITS;
          nxt_s.p1_drive = 1'b0;
        end else if (io_addr == ADDR_PORT2) begin
          nxt_s.rdata = port2_pins;
        end else if (io_addr == ADDR_PORT5) begin
          nxt_s.rdata = port5_pins;
        end else if (io_addr == ADDR_T12_GATE) begin
          nxt_s.rdata = t12_rd;
        end else if (io_addr == ADDR_SERIAL_BUF) begin
          if (second) begin
            nxt_s.rdata = s_ff.hold;
          end else begin
            nxt_s.rdata = rx_byte[3:0];
            nxt_s.hold  = rx_byte[7:4]; // byte cannot tear between nibbles
          end
        end else if (io_addr == ADDR_SERIAL_STAT) begin
          nxt_s.rdata = serial_status;
        end else if (io_addr == ADDR_T3_GATE) begin
          nxt_s.rdata = t3_rd;
        end else if (io_addr == ADDR_T3_CTRL) begin
          nxt_s.rdata = t3_status;
        end else if (io_addr == ADDR_VMON) begin
          nxt_s.rdata = vmon_status;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_ff.rdata    <= IDLE_READ;
      s_ff.rvalid   <= 1'b0;
      s_ff.p1_out   <= RST_PORT1;
      s_ff.p1_drive <= 1'b0;
      s_ff.p2_out   <= RST_ONES;
      s_ff.p2_dir   <= RST_ONES;
      s_ff.p5_out   <= RST_ONES;
      s_ff.p5_ctrl  <= RST_PORT5_CTRL;
      s_ff.tx       <= RST_TX_BYTE;
      s_ff.tx_load  <= 1'b0;
      s_ff.serial_control_one     <= RST_ONES;
      s_ff.serial_status_control     <= RST_SERIAL_STAT;
      s_ff.serial_control_two     <= RST_ONES;
      s_ff.t3c      <= RST_T3_CTRL;
      s_ff.voltage_monitor_control      <= RST_ONES;
      s_ff.hi       <= 1'b0;
      s_ff.hi_aux   <= 1'b0;
      s_ff.hi_write <= 1'b0;
      s_ff.hi_addr  <= 4'h0;
      s_ff.hold     <= RST_HOLD;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from state
  // ----------------------------------------------------------------
  assign io_rdata         = s_ff.rdata;
  assign io_rvalid        = s_ff.rvalid;
  assign port1_out        = s_ff.p1_out;
  assign port1_drive      = s_ff.p1_drive;
  assign port2_out        = s_ff.p2_out;
  assign port2_dir        = s_ff.p2_dir;
  assign port5_out        = s_ff.p5_out;
  assign port5_ctrl       = s_ff.p5_ctrl;
  assign tx_byte          = s_ff.tx;
  assign tx_load          = s_ff.tx_load;
  assign serial_ctrl1     = s_ff.serial_control_one;
  assign serial_stat_ctrl = s_ff.serial_status_control;
  assign serial_ctrl2     = s_ff.serial_control_two;
  assign t3_ctrl          = s_ff.t3c;
  assign vmon_ctrl        = s_ff.voltage_monitor_control;
endmodule
`default_nettype wire

// >>> verif/io_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural core issuing nibble-wide IN and OUT accesses
module io_core_model (
  input  wire logic       sys_clk,
  output logic            io_valid,
  output logic            io_write,
  output logic [3:0]      io_addr,
  output logic [3:0]      io_wdata,
  input  wire logic [3:0] io_rdata,
  input  wire logic       io_rvalid
);
  // bus quiet from time zero, no access during reset
  initial begin
    io_valid = 1'b0;
    io_write = 1'b0;
    io_addr  = 4'h0;
    io_wdata = 4'h0;
  end
  // caller sits just after an edge; request holds up to the taking edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [3:0] d);
    io_valid = 1'b1;
    io_write = w;
    io_addr  = a;
    io_wdata = d;
    @(posedge sys_clk);
    #1;
  endtask
  // released lines flip so a stale address never looks valid
  task automatic idle();
    io_valid = 1'b0;
    io_addr  = ~io_addr;
    io_wdata = ~io_wdata;
    @(posedge sys_clk);
    #1;
  endtask
  // the answer stands in the cycle after the taking edge
  task automatic rd(input logic [3:0] a, output logic [3:0] d, output logic ok);
    acc(1'b0, a, 4'h0);
    d  = io_rdata;
    ok = io_rvalid;
  endtask
  // byte registers: low nibble first, then high
  task automatic wr_byte(input logic [3:0] a, input logic [7:0] b);
    acc(1'b1, a, b[3:0]);
    acc(1'b1, a, b[7:4]);
  endtask
  // switch the next access of a module to its auxiliary register
  task automatic sel_aux(input logic [3:0] a);
    acc(1'b1, 4'h8, a);
  endtask
endmodule
`default_nettype wire

// >>> verif/io_bus_decoder_sva.sv
`timescale 1ns/1ps
`default_nettype none
module io_bus_decoder_sva
  import io_bus_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       io_valid,
  input wire logic       io_write,
  input wire logic [3:0] io_addr,
  input wire logic [3:0] io_wdata,
  input wire logic [3:0] io_rdata,
  input wire logic       io_rvalid,
  input wire logic [3:0] t3_status,
  input wire logic [3:0] vmon_status,
  input wire logic       tx_load,
  input wire logic [3:0] port1_out,
  input wire logic [3:0] port2_out,
  input wire logic [3:0] port2_dir,
  input wire logic [7:0] port5_ctrl,
  input wire logic [3:0] t3_ctrl,
  input wire logic [3:0] vmon_ctrl
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic rd_take;
  logic wr_take;
  // taken accesses, split by direction
  assign rd_take = io_valid && !io_write;
  assign wr_take = io_valid && io_write;
  AST_READ_ANSWER: assert property (rd_take |=> io_rvalid)
    else $error("read access not answered");
  AST_NO_SPURIOUS: assert property (io_rvalid |-> $past(rd_take))
    else $error("read answer without a read");
  AST_TX_CAUSE: assert property (tx_load |->
    $past(wr_take && io_addr == ADDR_SERIAL_BUF))
    else $error("stray transmit load");
  AST_T3_STATUS: assert property (rd_take && io_addr == ADDR_T3_CTRL |=>
    io_rdata == $past(t3_status))
    else $error("timer three status read wrong");
  AST_VMON_STATUS: assert property (rd_take && io_addr == ADDR_VMON |=>
    io_rdata == $past(vmon_status))
    else $error("voltage monitor status read wrong");
  AST_T3_CTRL_WR: assert property (wr_take && io_addr == ADDR_T3_CTRL |=>
    t3_ctrl == $past(io_wdata))
    else $error("timer three control not written");
  AST_VMON_WR: assert property (wr_take && io_addr == ADDR_VMON |=>
    vmon_ctrl == $past(io_wdata))
    else $error("voltage monitor control not written");
  AST_RSV_READ: assert property (rd_take && io_addr inside {4'hD, 4'hE} |=>
    io_rdata == 4'hF)
    else $error("reserved read not harmless");
  AST_RSV_WRITE: assert property (wr_take && io_addr inside {4'hD, 4'hE} |=>
    $stable(port2_out) && $stable(t3_ctrl) && $stable(vmon_ctrl) && !tx_load)
    else $error("reserved write had an effect");
  AST_ASW_WO: assert property (rd_take && io_addr == ADDR_AUX_SWITCH |=>
    io_rdata == 4'hF)
    else $error("aux switch readable");
  AST_P1_MASK: assert property (port1_out[2:1] == 2'b00)
    else $error("port one unused bits set");
  AST_RESET_VALUES: assert property ($fell(rst) |->
    port2_dir == 4'hF && port5_ctrl == 8'hFF && t3_ctrl == 4'h0 && port1_out == 4'h9)
    else $error("reset values wrong");
  // main traffic seen at least once
  COV_TX: cover property (tx_load);
  COV_CAP: cover property (rd_take && io_addr == ADDR_T3_GATE ##1 rd_take);
  COV_RSV: cover property (wr_take && io_addr == 4'hD);
endmodule
bind io_bus_decoder io_bus_decoder_sva i_sva (
  .sys_clk(sys_clk), .rst(rst), .io_valid(io_valid), .io_write(io_write),
  .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
  .t3_status(t3_status), .vmon_status(vmon_status), .tx_load(tx_load),
  .port1_out(port1_out), .port2_out(port2_out), .port2_dir(port2_dir),
  .port5_ctrl(port5_ctrl), .t3_ctrl(t3_ctrl), .vmon_ctrl(vmon_ctrl));
`default_nettype wire

// >>> verif/tb_io_bus_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_io_bus_decoder;
  logic         sys_clk, rst, io_valid, io_write, io_rvalid, port1_drive, tx_load, ok;
  logic [3:0]   io_addr, io_wdata, io_rdata, port1_pins, port2_pins, port5_pins, d;
  logic [3:0]   serial_status, t3_status, vmon_status, port1_out, port2_out, port2_dir;
  logic [3:0]   port5_out, serial_ctrl1, serial_stat_ctrl, serial_ctrl2, t3_ctrl, vmon_ctrl;
  logic [7:0]   rx_byte, t3_capture, port5_ctrl, tx_byte;
  logic [127:0] t12_regs, t3_regs, exp;
  int           fails, n_compared;
  io_bus_decoder i_dut (.sys_clk(sys_clk), .rst(rst), .io_valid(io_valid),
    .io_write(io_write), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .port1_pins(port1_pins), .port2_pins(port2_pins),
    .port5_pins(port5_pins), .rx_byte(rx_byte), .serial_status(serial_status),
    .t3_capture(t3_capture), .t3_status(t3_status), .vmon_status(vmon_status),
    .port1_out(port1_out), .port1_drive(port1_drive), .port2_out(port2_out),
    .port2_dir(port2_dir), .port5_out(port5_out), .port5_ctrl(port5_ctrl),
    .tx_byte(tx_byte), .tx_load(tx_load), .serial_ctrl1(serial_ctrl1),
    .serial_stat_ctrl(serial_stat_ctrl), .serial_ctrl2(serial_ctrl2), .t3_ctrl(t3_ctrl),
    .vmon_ctrl(vmon_ctrl), .t12_regs(t12_regs), .t3_regs(t3_regs));
  io_core_model i_core (.sys_clk(sys_clk), .io_valid(io_valid), .io_write(io_write),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid));
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    i_core.rd(4'h8, d, ok);
    i_core.idle();
    `CHK("asw_rd", 4'hF, d);
    `CHK("port2_dir", 4'hF, port2_dir);
    `CHK("stat_ctrl", 4'hB, serial_stat_ctrl);
    `CHK("ctrl12", 8'hFF, {serial_ctrl1, serial_ctrl2});
    `CHK("vmon_ctrl", 4'hF, vmon_ctrl);
    `CHK("t12", 128'h00000000_000F070F_0000FF0F_000F0F00, t12_regs);
    `CHK("t3", 128'h00000000_00000000_000FFFFF_00000F0F, t3_regs);
    $display("t_reset done");
  endtask
  // six primaries written back to back, then read through a table
  task automatic t_primary();
    logic [3:0] ra [6];
    logic [3:0] re [6];
    ra = '{4'h1, 4'h2, 4'h5, 4'hA, 4'hC, 4'hF};
    re = '{4'h9, 4'h6, 4'h3, 4'hC, 4'h7, 4'hD};
    i_core.acc(1'b1, 4'h1, 4'hF);
    i_core.acc(1'b1, 4'h2, 4'h5);
    i_core.acc(1'b1, 4'h5, 4'hA);
    i_core.acc(1'b1, 4'hA, 4'h4);
    i_core.acc(1'b1, 4'hC, 4'h3);
    i_core.acc(1'b1, 4'hF, 4'h2);
    i_core.idle();
    `CHK("port1", 5'h19, {port1_drive, port1_out});
    `CHK("port2", 8'hF5, {port2_dir, port2_out});
    `CHK("port5", 4'hA, port5_out);
    `CHK("ctrls", 12'h432, {serial_stat_ctrl, t3_ctrl, vmon_ctrl});
    for (int i = 0; i < 6; i++) begin
      i_core.rd(ra[i], d, ok);
      `CHK("rvalid", 1'b1, ok);
      `CHK("rdata", re[i], d);
    end
    i_core.idle();
    `CHK("port1_drive", 1'b0, port1_drive);
    $display("t_primary done");
  endtask
  // auxiliary routing, consumption and an unrelated access in between
  task automatic t_aux();
    i_core.sel_aux(4'h2);
    i_core.acc(1'b1, 4'h2, 4'h5);
    i_core.acc(1'b1, 4'h2, 4'hA);
    i_core.sel_aux(4'h5);
    i_core.wr_byte(4'h5, 8'h3C);
    i_core.acc(1'b1, 4'h5, 4'h7);
    i_core.sel_aux(4'hA);
    i_core.acc(1'b1, 4'h2, 4'h3);
    i_core.acc(1'b1, 4'hA, 4'h6);
    i_core.sel_aux(4'h9);
    i_core.acc(1'b1, 4'h9, 4'h1);
    i_core.idle();
    `CHK("port2", 8'h53, {port2_dir, port2_out});
    `CHK("port5", 12'h3C7, {port5_ctrl, port5_out});
    `CHK("ser", 12'h461, {serial_stat_ctrl, serial_ctrl2, serial_ctrl1});
    `CHK("tx_byte", 8'h00, tx_byte);
    $display("t_aux done");
  endtask
  // byte transmit pulse and receive snapshot
  task automatic t_serial();
    i_core.wr_byte(4'h9, 8'h5A);
    `CHK("tx_load", 1'b1, tx_load);
    `CHK("tx_byte", 8'h5A, tx_byte);
    i_core.idle();
    `CHK("tx_load_off", 1'b0, tx_load);
    i_core.rd(4'h9, d, ok);
    `CHK("rx_lo", 4'h5, d);
    rx_byte = 8'h00;
    i_core.rd(4'h9, d, ok);
    `CHK("rx_hi", 4'hA, d);
    i_core.idle();
    $display("t_serial done");
  endtask
  // subport banks, reserved subports and capture pair
  task automatic t_sub();
    exp = 128'h00000000_000F070F_0000FF0F_000F0F00;
    i_core.acc(1'b1, 4'h7, 4'h0);
    i_core.acc(1'b1, 4'h7, 4'h5);
    i_core.acc(1'b1, 4'h7, 4'h5);
    i_core.wr_byte(4'h7, 8'hC3);
    i_core.acc(1'b1, 4'h7, 4'h6);
    i_core.acc(1'b1, 4'h7, 4'h3);
    i_core.acc(1'b1, 4'h7, 4'hA);
    i_core.acc(1'b1, 4'h7, 4'h1);
    i_core.rd(4'h7, d, ok);
    i_core.idle();
    exp[3:0] = 4'h5;
    exp[47:40] = 8'hC3;
    exp[83:80] = 4'h1;
    `CHK("t12", exp, t12_regs);
    `CHK("gate7_rd", 4'hF, d);
    i_core.acc(1'b1, 4'hB, 4'h2);
    i_core.acc(1'b1, 4'hB, 4'hD);
    i_core.acc(1'b1, 4'hB, 4'h8);
    i_core.acc(1'b1, 4'hB, 4'h3);
    i_core.acc(1'b1, 4'hB, 4'h4);
    i_core.rd(4'hB, d, ok);
    `CHK("cap_lo", 4'hC, d);
    t3_capture = 8'h00;
    i_core.rd(4'hB, d, ok);
    `CHK("cap_hi", 4'h3, d);
    i_core.rd(4'hB, d, ok);
    `CHK("sub_rd", 4'hF, d);
    i_core.acc(1'b1, 4'hB, 4'h4);
    i_core.wr_byte(4'hB, 8'h96);
    i_core.idle();
    exp = 128'h00000000_00000000_000FFFFF_00000F0F;
    exp[19:16] = 4'hD;
    exp[39:32] = 8'h96;
    `CHK("t3", exp, t3_regs);
    $display("t_sub done");
  endtask
  // reserved module addresses change nothing
  task automatic t_reserved();
    logic [3:0]  ra [6];
    logic [35:0] snap;
    ra = '{4'h0, 4'h3, 4'h4, 4'h6, 4'hD, 4'hE};
    snap = {port2_out, port5_out, port2_dir, t3_ctrl, vmon_ctrl, serial_ctrl1,
            serial_stat_ctrl, serial_ctrl2, port1_out};
    for (int i = 0; i < 6; i++) begin
      i_core.acc(1'b1, ra[i], 4'h5);
    end
    i_core.rd(4'hE, d, ok);
    i_core.idle();
    `CHK("rsv_rd", 4'hF, d);
    `CHK("rsv_wr", snap, {port2_out, port5_out, port2_dir, t3_ctrl, vmon_ctrl, serial_ctrl1,
      serial_stat_ctrl, serial_ctrl2, port1_out});
    $display("t_reserved done");
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // 125 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // cut a hang short well inside the cycle budget
  initial begin
    #400000;
    fails++;
    results();
  end
  initial begin
    fails = 0;
    n_compared = 0;
    rst = 1'b1;
    port1_pins = 4'hF;
    port2_pins = 4'h6;
    port5_pins = 4'h3;
    rx_byte = 8'hA5;
    serial_status = 4'hC;
    t3_capture = 8'h3C;
    t3_status = 4'h7;
    vmon_status = 4'hD;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_primary();
    t_aux();
    t_serial();
    t_sub();
    t_reserved();
    results();
  end
endmodule
`default_nettype wire
